/* File: logic/card_atr_pkg.sv */
package card_atr_pkg;
  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned CLASS_W   = 5;
  localparam int unsigned ETU_CNT_W = 9;
  localparam int unsigned BIT_CNT_W = 4;
  localparam int unsigned IDX_W     = 3;

  // ------------------------------------------------------------
  // Card clock timing, in card clock cycles; frame lengths in bits
  // ------------------------------------------------------------
  localparam logic [ETU_CNT_W-1:0] ETU_CLOCKS       = 9'h174; // 372 clocks per bit
  localparam logic [ETU_CNT_W-1:0] ATR_DELAY_CLOCKS = 9'h190; // 400 clocks after reset
  localparam logic [BIT_CNT_W-1:0] FRAME_DRIVEN     = 4'ha;   // Start, 8 data, parity
  localparam logic [BIT_CNT_W-1:0] FRAME_TOTAL      = 4'hc;   // Plus two guard bits

  // ------------------------------------------------------------
  // Answer-to-reset layout
  // ------------------------------------------------------------
  localparam logic [IDX_W-1:0]  ATR_IDX_TS    = 3'h0;
  localparam logic [IDX_W-1:0]  ATR_IDX_T0    = 3'h1;
  localparam logic [IDX_W-1:0]  ATR_IDX_TD1   = 3'h2;
  localparam logic [IDX_W-1:0]  ATR_IDX_TD2   = 3'h3;
  localparam logic [IDX_W-1:0]  ATR_IDX_CLASS = 3'h4;
  localparam logic [IDX_W-1:0]  ATR_IDX_TCK   = 3'h5;
  localparam logic [BYTE_W-1:0] ATR_TS        = 8'h3b; // Direct convention
  localparam logic [BYTE_W-1:0] ATR_T0        = 8'h80; // TD1 follows, no historical bytes
  localparam logic [BYTE_W-1:0] ATR_TD1       = 8'h80; // TD2 follows, protocol 0
  localparam logic [BYTE_W-1:0] ATR_TD2       = 8'h1f; // First global byte follows, T=15

  // ------------------------------------------------------------
  // Class indication byte fields
  // ------------------------------------------------------------
  localparam int unsigned       CLASS_LSB        = 0;
  localparam int unsigned       CLOCK_STOP_LSB   = 6;
  localparam logic [1:0]        CLOCK_STOP_FIELD = 2'h3; // No preference
  localparam logic [CLASS_W-1:0] CLASS_A_ONLY    = 5'h01;

  // ------------------------------------------------------------
  // Card-side sequencing
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_RESET = 4'h1,
    ST_WAIT  = 4'h2,
    ST_ATR   = 4'h4,
    ST_DATA  = 4'h8
  } card_state_t;
endpackage

/* File: logic/card_atr_responder.sv */
`timescale 1ns/1ns
module card_atr_responder (
  input  wire logic                               SYS_CLK,
  input  wire logic                               SYS_RST,
  input  wire logic                               CARD_CLK,
  input  wire logic                               CARD_RST_N,
  input  wire logic [card_atr_pkg::CLASS_W-1:0]   CLASS_SUPPORT,
  input  wire logic [card_atr_pkg::BYTE_W-1:0]    USER_DATA,
  input  wire logic                               USER_VALID,
  output logic                                    USER_READY,
  output logic                                    ATR_DONE,
  output logic                                    IO_OUT,
  output logic                                    IO_OE
);
  import card_atr_pkg::*;

  // ------------------------------------------------------------
  // System side: two-entry buffer and word handshake
  // ------------------------------------------------------------
  logic [BYTE_W-1:0] buf_mem [2];
  logic              wr_ptr;
  logic              rd_ptr;
  logic [1:0]        count;
  logic [BYTE_W-1:0] xfer_data;
  logic              xfer_req;
  logic              ack_meta;
  logic              ack_sync;
  logic              done_meta;
  logic              next_wr_ptr;
  logic              next_rd_ptr;
  logic [1:0]        next_count;
  logic [BYTE_W-1:0] next_xfer_data;
  logic              next_xfer_req;
  logic              next_ready;
  logic              push;
  logic              pop;
  logic              card_ack;
  logic              card_done;

  // Ready is registered, so it reflects the count after this edge
  always_comb begin
    push           = USER_VALID && USER_READY;
    pop            = (count != 2'h0) && (ack_sync == xfer_req);
    next_wr_ptr    = push ? ~wr_ptr : wr_ptr;
    next_rd_ptr    = pop ? ~rd_ptr : rd_ptr;
    next_count     = count + {1'b0, push} - {1'b0, pop};
    next_xfer_data = pop ? buf_mem[rd_ptr] : xfer_data;
    next_xfer_req  = pop ? ~xfer_req : xfer_req;
    next_ready     = (next_count != 2'h2);
  end

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      buf_mem[0] <= 8'h00;
      buf_mem[1] <= 8'h00;
      wr_ptr     <= 1'b0;
      rd_ptr     <= 1'b0;
      count      <= 2'h0;
      xfer_data  <= 8'h00;
      xfer_req   <= 1'b0;
      USER_READY <= 1'b0;
      ack_meta   <= 1'b0;
      ack_sync   <= 1'b0;
      done_meta  <= 1'b0;
      ATR_DONE   <= 1'b0;
    end else begin
      if (push) begin
        buf_mem[wr_ptr] <= USER_DATA;
      end
      wr_ptr     <= next_wr_ptr;
      rd_ptr     <= next_rd_ptr;
      count      <= next_count;
      xfer_data  <= next_xfer_data;
      xfer_req   <= next_xfer_req;
      USER_READY <= next_ready;
      ack_meta   <= card_ack;
      ack_sync   <= ack_meta;
      done_meta  <= card_done;
      ATR_DONE   <= done_meta;
    end
  end

  // ------------------------------------------------------------
  // Card side: input synchronisers on the card clock
  // ------------------------------------------------------------
  logic               rst_meta;
  logic               rst_sync;
  logic               req_meta;
  logic               req_sync;
  logic [CLASS_W-1:0] strap_meta;
  logic [CLASS_W-1:0] strap_sync;

  always_ff @(posedge CARD_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rst_meta   <= 1'b0;
      rst_sync   <= 1'b0;
      req_meta   <= 1'b0;
      req_sync   <= 1'b0;
      strap_meta <= 5'h00;
      strap_sync <= 5'h00;
    end else begin
      rst_meta   <= CARD_RST_N;
      rst_sync   <= rst_meta;
      req_meta   <= xfer_req;
      req_sync   <= req_meta;
      strap_meta <= CLASS_SUPPORT;
      strap_sync <= strap_meta;
    end
  end

  // ------------------------------------------------------------
  // Class set reduced to its lowest contiguous run
  // ------------------------------------------------------------
  // A gap would advertise an illegal pattern, so upper classes are dropped
  logic [CLASS_W:0]   lower_none;
  logic [CLASS_W-1:0] run;
  logic [CLASS_W-1:0] class_set;

  assign lower_none[0] = 1'b1;
  genvar gi;
  generate
    for (gi = 0; gi < CLASS_W; gi++) begin : g_run
      assign lower_none[gi+1] = lower_none[gi] & ~strap_sync[gi];
      if (gi == 0) begin : g_first
        assign run[gi] = strap_sync[gi];
      end else begin : g_next
        assign run[gi] = strap_sync[gi] & (lower_none[gi] | run[gi-1]);
      end
    end
  endgenerate
  assign class_set = (run == 5'h00) ? CLASS_A_ONLY : run;

  // ------------------------------------------------------------
  // Card side: answer-to-reset and data transmitter
  // ------------------------------------------------------------
  card_state_t          state;
  logic [ETU_CNT_W-1:0] wait_cnt;
  logic [IDX_W-1:0]     atr_idx;
  logic [BYTE_W-1:0]    class_byte;
  logic [BYTE_W-1:0]    tck;
  logic                 busy;
  logic [ETU_CNT_W-1:0] etu_cnt;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [9:0]           frame;
  logic [BYTE_W-1:0]    hold_data;
  logic                 hold_full;
  card_state_t          next_state;
  logic [ETU_CNT_W-1:0] next_wait_cnt;
  logic [IDX_W-1:0]     next_atr_idx;
  logic [BYTE_W-1:0]    next_class_byte;
  logic [BYTE_W-1:0]    next_tck;
  logic                 next_busy;
  logic [ETU_CNT_W-1:0] next_etu_cnt;
  logic [BIT_CNT_W-1:0] next_bit_cnt;
  logic [9:0]           next_frame;
  logic [BYTE_W-1:0]    next_hold_data;
  logic                 next_hold_full;
  logic                 next_card_ack;
  logic                 next_card_done;
  logic                 next_io_out;
  logic                 next_io_oe;
  logic [BYTE_W-1:0]    atr_byte;
  logic                 load;
  logic [BYTE_W-1:0]    load_byte;
  logic                 frame_end;

  always_comb begin
    case (atr_idx)
      ATR_IDX_TS:    atr_byte = ATR_TS;
      ATR_IDX_T0:    atr_byte = ATR_T0;
      ATR_IDX_TD1:   atr_byte = ATR_TD1;
      ATR_IDX_TD2:   atr_byte = ATR_TD2;
      ATR_IDX_CLASS: atr_byte = class_byte;
      default:       atr_byte = tck;
    endcase
  end

  always_comb begin
    next_state      = state;
    next_wait_cnt   = wait_cnt;
    next_atr_idx    = atr_idx;
    next_class_byte = class_byte;
    next_tck        = tck;
    next_busy       = busy;
    next_etu_cnt    = etu_cnt;
    next_bit_cnt    = bit_cnt;
    next_frame      = frame;
    next_hold_data  = hold_data;
    next_hold_full  = hold_full;
    next_card_ack   = card_ack;
    next_card_done  = card_done;
    load            = 1'b0;
    load_byte       = atr_byte;
    frame_end       = 1'b0;

    // Word crossing: accept only when the holding register is free
    if ((req_sync != card_ack) && !hold_full) begin
      next_hold_data = xfer_data;
      next_hold_full = 1'b1;
      next_card_ack  = ~card_ack;
    end

    // Bit timing
    if (busy) begin
      if (etu_cnt == ETU_CLOCKS - 9'h001) begin
        next_etu_cnt = 9'h000;
        if (bit_cnt == FRAME_TOTAL - 4'h1) begin
          next_busy = 1'b0;
          frame_end = 1'b1;
        end else begin
          next_bit_cnt = bit_cnt + 4'h1;
        end
      end else begin
        next_etu_cnt = etu_cnt + 9'h001;
      end
    end

    case (state)
      ST_RESET: begin
        next_card_done = 1'b0;
        if (rst_sync) begin
          next_state      = ST_WAIT;
          next_wait_cnt   = 9'h000;
          next_atr_idx    = ATR_IDX_TS;
          next_tck        = 8'h00;
          next_class_byte = 8'h00;
          next_class_byte[CLOCK_STOP_LSB +: 2]   = CLOCK_STOP_FIELD;
          next_class_byte[CLASS_LSB +: CLASS_W]  = class_set;
        end
      end
      ST_WAIT: begin
        if (wait_cnt == ATR_DELAY_CLOCKS - 9'h001) begin
          next_state = ST_ATR;
        end else begin
          next_wait_cnt = wait_cnt + 9'h001;
        end
      end
      ST_ATR: begin
        // User words wait here, so the answer always goes out first
        if (!busy && !frame_end) begin
          load = 1'b1;
          if (atr_idx != ATR_IDX_TS) begin
            next_tck = tck ^ atr_byte;
          end
          if (atr_idx == ATR_IDX_TCK) begin
            next_state     = ST_DATA;
            next_card_done = 1'b1;
          end else begin
            next_atr_idx = atr_idx + 3'h1;
          end
        end
      end
      ST_DATA: begin
        if (!busy && !frame_end && hold_full) begin
          load           = 1'b1;
          load_byte      = hold_data;
          next_hold_full = 1'b0;
        end
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase

    if (load) begin
      next_busy    = 1'b1;
      next_etu_cnt = 9'h000;
      next_bit_cnt = 4'h0;
      next_frame   = {^load_byte, load_byte, 1'b0};
    end

    // Card reset pulls the sequence back; a word already held survives it
    if (!rst_sync) begin
      next_state     = ST_RESET;
      next_busy      = 1'b0;
      next_card_done = 1'b0;
    end

    // Open-drain line: drive only low bits of the frame, release the rest
    next_io_out = 1'b0;
    next_io_oe  = 1'b0;
    if (next_busy && (next_bit_cnt < FRAME_DRIVEN)) begin
      next_io_oe = ~next_frame[next_bit_cnt];
    end
  end

  always_ff @(posedge CARD_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state      <= ST_RESET;
      wait_cnt   <= 9'h000;
      atr_idx    <= 3'h0;
      class_byte <= 8'h00;
      tck        <= 8'h00;
      busy       <= 1'b0;
      etu_cnt    <= 9'h000;
      bit_cnt    <= 4'h0;
      frame      <= 10'h3ff;
      hold_data  <= 8'h00;
      hold_full  <= 1'b0;
      card_ack   <= 1'b0;
      card_done  <= 1'b0;
      IO_OUT     <= 1'b0;
      IO_OE      <= 1'b0;
    end else begin
      state      <= next_state;
      wait_cnt   <= next_wait_cnt;
      atr_idx    <= next_atr_idx;
      class_byte <= next_class_byte;
      tck        <= next_tck;
      busy       <= next_busy;
      etu_cnt    <= next_etu_cnt;
      bit_cnt    <= next_bit_cnt;
      frame      <= next_frame;
      hold_data  <= next_hold_data;
      hold_full  <= next_hold_full;
      card_ack   <= next_card_ack;
      card_done  <= next_card_done;
      IO_OUT     <= next_io_out;
      IO_OE      <= next_io_oe;
    end
  end
endmodule // card_atr_responder

/* File: verification/card_atr_monitor.sv */
`timescale 1ns/1ns
module card_atr_monitor (
  input wire logic                             SYS_CLK,
  input wire logic                             SYS_RST,
  input wire logic                             CARD_CLK,
  input wire logic                             CARD_RST_N,
  input wire logic [card_atr_pkg::CLASS_W-1:0] CLASS_SUPPORT,
  input wire logic [card_atr_pkg::BYTE_W-1:0]  USER_DATA,
  input wire logic                             USER_VALID,
  input wire logic                             USER_READY,
  input wire logic                             ATR_DONE,
  input wire logic                             IO_OUT,
  input wire logic                             IO_OE
);
  import card_atr_pkg::*;
  // ------------------------------------------------------------
  // Card clock counters
  // ------------------------------------------------------------
  logic [15:0] age;
  logic [15:0] next_age;
  logic [15:0] since;
  logic [15:0] next_since;
  logic        oe_q;
  // Saturate so a long idle never wraps into a false failure
  always_comb begin
    next_age = (age == 16'hffff) ? age : age + 16'h1;
    if (!CARD_RST_N) next_age = 16'h0;
    next_since = (since == 16'hffff) ? since : since + 16'h1;
    if (IO_OE != oe_q) next_since = 16'h1;
  end
  always_ff @(posedge CARD_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      age   <= 16'h0;
      since <= 16'hffff;
      oe_q  <= 1'b0;
    end else begin
      age   <= next_age;
      since <= next_since;
      oe_q  <= IO_OE;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  AST_OE_IN_RESET: assert property (@(posedge CARD_CLK) disable iff (SYS_RST)
    !CARD_RST_N [*5] |-> !IO_OE) else $error("line driven while card held in reset");
  AST_DRIVE_LOW: assert property (@(posedge CARD_CLK) disable iff (SYS_RST)
    IO_OE |-> !IO_OUT) else $error("open drain output not low");
  AST_ANSWER_WAIT: assert property (@(posedge CARD_CLK) disable iff (SYS_RST)
    (age > 16'h4 && age < 16'h18e) |-> !IO_OE) else $error("answer started early");
  AST_ANSWER_START: assert property (@(posedge CARD_CLK) disable iff (SYS_RST)
    age == 16'h19a |-> IO_OE) else $error("answer start bit missing");
  AST_BIT_TIME: assert property (@(posedge CARD_CLK) disable iff (SYS_RST)
    $changed(IO_OE) && CARD_RST_N |-> since >= 16'h174) else $error("bit shorter than etu");
  AST_DONE_IN_RESET: assert property (@(posedge CARD_CLK) disable iff (SYS_RST)
    !CARD_RST_N [*8] |-> !ATR_DONE) else $error("done high during card reset");
  AST_DONE_RISE: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    $rose(ATR_DONE) |-> age >= 16'h5730) else $error("done before answer loaded");
  AST_DONE_HOLD: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    ATR_DONE && CARD_RST_N && $past(CARD_RST_N, 4) |=> ATR_DONE) else $error("done dropped");
endmodule // card_atr_monitor

bind card_atr_responder card_atr_monitor u_card_atr_monitor (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .CARD_CLK(CARD_CLK), .CARD_RST_N(CARD_RST_N),
  .CLASS_SUPPORT(CLASS_SUPPORT), .USER_DATA(USER_DATA), .USER_VALID(USER_VALID),
  .USER_READY(USER_READY), .ATR_DONE(ATR_DONE), .IO_OUT(IO_OUT), .IO_OE(IO_OE));

/* File: verification/card_terminal_model.sv */
`timescale 1ns/1ns
module card_terminal_model (
  input  wire logic activate,
  input  wire logic io_line,
  output logic      card_clk,
  output logic      card_rst_n,
  output logic [7:0] rx_byte,
  output logic      rx_par_ok,
  output logic      rx_stb
);
  // ------------------------------------------------------------
  // Clock, reset and character receiver
  // ------------------------------------------------------------
  initial begin
    card_clk = 1'b0;
    card_rst_n = 1'b0;
    forever begin
      #62 card_clk = 1'b1;
      #63 card_clk = 1'b0;
    end
  end
  always @(posedge card_clk) card_rst_n <= activate;
  // Mid-bit sampling; any byte kind is accepted, check byte too
  initial begin
    rx_stb = 1'b0;
    rx_byte = 8'h00;
    rx_par_ok = 1'b0;
    forever begin
      @(negedge io_line);
      repeat (186) @(posedge card_clk);
      for (int i = 0; i < 9; i++) begin
        repeat (372) @(posedge card_clk);
        if (i < 8) rx_byte[i] = io_line;
        else rx_par_ok = ((^rx_byte) == io_line);
      end
      rx_stb = 1'b1;
      #1 rx_stb = 1'b0;
    end
  end
endmodule // card_terminal_model

/* File: verification/tb.sv */
`timescale 1ns/1ns
module tb;
  import card_atr_pkg::*;
  logic       SYS_CLK;
  logic       SYS_RST;
  logic       CARD_CLK;
  logic       CARD_RST_N;
  logic [7:0] USER_DATA;
  logic       USER_VALID;
  logic       USER_READY;
  logic       ATR_DONE;
  logic       IO_OUT;
  logic       IO_OE;
  logic       activate;
  logic       io_line;
  logic [7:0] rx_byte;
  logic       rx_par_ok;
  logic       rx_stb;
  logic [4:0] class_strap;
  logic [7:0] rxq[$];
  logic [7:0] sent[$];
  int         n_mismatch = 0;
  int         num_checks = 0;

  // Pull-up on the shared line
  assign io_line = IO_OE ? IO_OUT : 1'b1;

  card_atr_responder u_card_atr_responder (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .CARD_CLK(CARD_CLK), .CARD_RST_N(CARD_RST_N), .CLASS_SUPPORT(class_strap),
    .USER_DATA(USER_DATA), .USER_VALID(USER_VALID), .USER_READY(USER_READY),
    .ATR_DONE(ATR_DONE), .IO_OUT(IO_OUT), .IO_OE(IO_OE));
  card_terminal_model u_card_terminal_model (.activate(activate), .io_line(io_line),
    .card_clk(CARD_CLK), .card_rst_n(CARD_RST_N), .rx_byte(rx_byte),
    .rx_par_ok(rx_par_ok), .rx_stb(rx_stb));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge rx_stb) begin
    rxq.push_back(rx_byte);
    check("parity", {7'h0, rx_par_ok}, 8'h01);
  end

  // Holds the byte until the design takes it; READY is registered, so a
  // negedge sample tells whether the next rising edge transfers
  task automatic send(input logic [7:0] d);
    int k;
    k = 0;
    @(negedge SYS_CLK);
    USER_VALID = 1'b1;
    USER_DATA = d;
    while (USER_READY !== 1'b1 && k < 200) begin
      k++;
      @(negedge SYS_CLK);
    end
    check("taken", {7'h0, USER_READY}, 8'h01);
    sent.push_back(d);
    @(negedge SYS_CLK);
    USER_VALID = 1'b0;
  endtask

  task automatic t_reset();
    repeat (2) @(negedge SYS_CLK);
    check("ready", {7'h0, USER_READY}, 8'h01);
    check("done", {7'h0, ATR_DONE}, 8'h00);
  endtask

  // User bytes wait while the card is held in reset; holding, crossing and
  // two buffer entries take four bytes, the fifth is refused
  task automatic t_fill();
    send(8'h5a);
    send(8'ha5);
    send(8'h3c);
    send(8'hc3);
    USER_VALID = 1'b1;
    USER_DATA = 8'h99;
    repeat (40) @(negedge SYS_CLK);
    check("full", {7'h0, USER_READY}, 8'h00);
    USER_VALID = 1'b0;
    check("quiet", 8'(rxq.size()), 8'h00);
  endtask

  // Reset lifted, then applied again before the answer begins
  task automatic t_abort();
    activate = 1'b1;
    repeat (200) @(posedge CARD_CLK);
    @(negedge SYS_CLK);
    check("early oe", {7'h0, IO_OE}, 8'h00);
    activate = 1'b0;
    repeat (20) @(posedge CARD_CLK);
    @(negedge SYS_CLK);
    check("abort done", {7'h0, ATR_DONE}, 8'h00);
    check("abort rx", 8'(rxq.size()), 8'h00);
  endtask

  // Gapped strap A+C must shrink to class A alone
  task automatic t_answer();
    logic [7:0] exp[$];
    logic [7:0] cls;
    int k;
    cls = {2'h3, 1'b0, 5'h01};
    exp = '{ATR_TS, ATR_T0, ATR_TD1, ATR_TD2, cls, ATR_T0 ^ ATR_TD1 ^ ATR_TD2 ^ cls};
    foreach (sent[i]) exp.push_back(sent[i]);
    k = 0;
    activate = 1'b1;
    // Ten characters of 12 etu each take about 113000 system clocks
    while (rxq.size() < exp.size() && k < 118000) begin
      k++;
      @(negedge SYS_CLK);
    end
    check("count", 8'(rxq.size()), 8'(exp.size()));
    check("common class", rxq[4] & 8'h01, 8'h01);
    foreach (exp[i]) check("byte", rxq[i], exp[i]);
    check("done", {7'h0, ATR_DONE}, 8'h01);
  endtask

  initial begin
    SYS_CLK = 1'b0;
    forever #25 SYS_CLK = ~SYS_CLK;
  end

  initial begin
    repeat (125000) @(posedge SYS_CLK);
    n_mismatch++;
    results();
  end

  initial begin
    SYS_RST = 1'b1;
    USER_VALID = 1'b0;
    USER_DATA = 8'h00;
    class_strap = 5'h05;
    activate = 1'b0;
    repeat (10) @(negedge SYS_CLK);
    SYS_RST = 1'b0;
    t_reset();
    t_fill();
    t_abort();
    t_answer();
    results();
  end
endmodule // tb
